// *** timer1_osc_defs.vh ***
// Summary of operation
// - oscillator enable bit starts secondary oscillator
// - oscillator keeps running in power-managed modes
// - clock select 01 enters secondary run
// - sleep with idle disabled enters secondary idle
// - status flag set when oscillator clocks system
// - status flag tracks source after oscillator failure
// - count wraps FFFFh to 0000h, sets flag
// - interrupt request only while enable bit set
// - compare trigger mode 1011 clears the count
// - second compare trigger also starts conversion
// - trigger reset in all modes, synchronous or not
// - count write beats a coincident trigger
// - second unit trigger never sets overflow flag
// - 32.768 kHz gives 2 s, msb preload 1 s
// - enabled oscillator pins read zero, output pin driven
// - source select picks instruction cycle or edge
`ifndef TIMER1_OSC_DEFS_VH
`define TIMER1_OSC_DEFS_VH
`define OFS_COUNT_LOW 4'h0
`define OFS_COUNT_HIGH 4'h4
`define OFS_TIMER_CONTROL 4'h8
`define OFS_FLAGS_ONE 4'hc
`define OFS_ENABLES_ONE 5'h10
`define OFS_PRIORITIES_ONE 5'h14
`define OFS_OSC_CONTROL 5'h18
`define BIT_WIDE_ACCESS 7
`define BIT_SYS_FROM_SEC 6
`define BIT_PRESCALE_LO 4
`define BIT_OSC_ENABLE 3
`define BIT_SYNC_SELECT 2
`define BIT_SOURCE_SELECT 1
`define BIT_COUNTER_ON 0
`define BIT_OVF_FLAG 0
`define BIT_IDLE_ENABLE 7
`define SCS_SECONDARY 2'h1
`define CMP_MODE_TRIGGER 4'hb
`define RESET_CONTROL 8'h00
`define INSTR_DIV 4
`endif

// *** timer1_osc_overflow_trigger.v ***
`timescale 1ns/1ns
`default_nettype none
`include "timer1_osc_defs.vh"
module timer1_osc_overflow_trigger (
	input wire core_clk,
	input wire srst,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire secOscInPin,
	input wire secOscOutPinIn,
	output wire secOscOutPinOut,
	output wire secOscOutPinOe,
	input wire extClockPin,
	output wire pinInputsRead,
	input wire sleepExecute,
	input wire secOscFailed,
	input wire compareAMatch,
	input wire [3:0] compareAMode,
	input wire compareAUsesTimer,
	input wire compareBMatch,
	input wire [3:0] compareBMode,
	input wire compareBUsesTimer,
	input wire adcEnabled,
	output reg adcStart,
	output wire overflowIrq,
	output wire overflowIrqHighPriority,
	output wire secOscRunning,
	output wire secRunMode,
	output reg secIdleMode
);
	parameter COUNT_WIDTH = 16;

	reg [7:0] timerControl;
	reg [7:0] oscControl;
	reg overflowIrqFlag;
	reg overflowIrqEnable;
	reg overflowIrqPriority;
	reg [COUNT_WIDTH-1:0] countPair;
	reg [7:0] highBuffer;
	reg ackDone;
	reg [1:0] instrDiv;
	reg [2:0] prescaleCnt;
	reg oscSync1, oscSync2, oscPrev;
	reg extSync1, extSync2, extPrev;
	reg [7:0] next_readHigh;
	wire secOscEnable = timerControl[`BIT_OSC_ENABLE];
	wire sourceSelect = timerControl[`BIT_SOURCE_SELECT];
	wire counterOn = timerControl[`BIT_COUNTER_ON];
	wire wideAccess = timerControl[`BIT_WIDE_ACCESS];
	wire [1:0] prescaleSel = timerControl[`BIT_PRESCALE_LO+1:`BIT_PRESCALE_LO];
	wire [1:0] systemClockSelect = oscControl[1:0];
	wire idleOnSleepEnable = oscControl[`BIT_IDLE_ENABLE];

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle for every access
	wire access = avs_read | avs_write;
	assign avs_waitrequest = access & ~ackDone;
	wire wrStb = avs_write & ackDone & avs_byteenable[0];
	wire rdStb = avs_read & ackDone;
	wire wrLow = wrStb && avs_address == `OFS_COUNT_LOW;
	wire wrHigh = wrStb && avs_address == `OFS_COUNT_HIGH;
	wire [7:0] wd = avs_writedata[7:0];

	always @(posedge core_clk) begin
		if (srst)
			ackDone <= 1'b0;
		else
			ackDone <= access & ~ackDone;
	end

	always @* begin
		next_readHigh = wideAccess ? highBuffer : countPair[15:8];
	end

	always @(posedge core_clk) begin
		if (srst) begin
			avs_readdata <= 32'h00000000;
		end else if (access & ~ackDone) begin
			case (avs_address)
			`OFS_COUNT_LOW: avs_readdata <= {24'h000000, countPair[7:0]};
			`OFS_COUNT_HIGH: avs_readdata <= {24'h000000, next_readHigh};
			`OFS_TIMER_CONTROL: avs_readdata <= {24'h000000, wideAccess,
				secOscRunning, timerControl[5:0]};
			`OFS_FLAGS_ONE: avs_readdata <= {31'h00000000, overflowIrqFlag};
			`OFS_ENABLES_ONE: avs_readdata <= {31'h00000000, overflowIrqEnable};
			`OFS_PRIORITIES_ONE: avs_readdata <= {31'h00000000, overflowIrqPriority};
			`OFS_OSC_CONTROL: avs_readdata <= {24'h000000, oscControl};
			default: avs_readdata <= 32'h00000000;
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			timerControl <= `RESET_CONTROL;
			oscControl <= 8'h00;
			overflowIrqEnable <= 1'b0;
			overflowIrqPriority <= 1'b1;
		end else if (wrStb) begin
			case (avs_address)
			`OFS_TIMER_CONTROL: timerControl <= {wd[7], 1'b0, wd[5:0]};
			`OFS_ENABLES_ONE: overflowIrqEnable <= wd[`BIT_OVF_FLAG];
			`OFS_PRIORITIES_ONE: overflowIrqPriority <= wd[`BIT_OVF_FLAG];
			`OFS_OSC_CONTROL: oscControl <= wd;
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator, clock status and power-managed modes
	// the oscillator enable is not touched by mode changes
	assign secOscRunning = secOscEnable & (systemClockSelect == `SCS_SECONDARY)
		& ~secOscFailed;
	assign secRunMode = secOscRunning;
	assign secOscOutPinOut = secOscEnable & ~oscSync2;
	assign secOscOutPinOe = secOscEnable;
	assign pinInputsRead = 1'b0;
	assign overflowIrq = overflowIrqFlag & overflowIrqEnable;
	assign overflowIrqHighPriority = overflowIrq & overflowIrqPriority;

	always @(posedge core_clk) begin
		if (srst)
			secIdleMode <= 1'b0;
		else if (sleepExecute && secOscRunning && !idleOnSleepEnable)
			secIdleMode <= 1'b1;
		else if (!secOscRunning || wrStb)
			secIdleMode <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisers and edge detect
	always @(posedge core_clk) begin
		if (srst) begin
			oscSync1 <= 1'b0;
			oscSync2 <= 1'b0;
			oscPrev <= 1'b0;
			extSync1 <= 1'b0;
			extSync2 <= 1'b0;
			extPrev <= 1'b0;
		end else begin
			oscSync1 <= secOscInPin;
			oscSync2 <= oscSync1;
			oscPrev <= oscSync2;
			extSync1 <= extClockPin;
			extSync2 <= extSync1;
			extPrev <= extSync2;
		end
	end

	wire oscRise = oscSync2 & ~oscPrev;
	wire extRise = extSync2 & ~extPrev;
	wire instrTick = instrDiv == 2'd3;
	wire rawTick = sourceSelect ? (secOscEnable ? oscRise : extRise) : instrTick;
	wire [2:0] prescaleLast = (3'd1 << prescaleSel) - 3'd1;
	wire countTick = counterOn & rawTick & (prescaleCnt == prescaleLast);

	always @(posedge core_clk) begin
		if (srst) begin
			instrDiv <= 2'd0;
			prescaleCnt <= 3'd0;
		end else begin
			instrDiv <= instrDiv + 2'd1;
			if (wrLow)
				prescaleCnt <= 3'd0;
			else if (counterOn & rawTick)
				prescaleCnt <= (prescaleCnt == prescaleLast) ? 3'd0 : prescaleCnt + 3'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// count pair, trigger reset, overflow flag
	// every tick is in core_clk domain, so trigger reset works in all modes
	wire trigA = compareAMatch & compareAUsesTimer & (compareAMode == `CMP_MODE_TRIGGER);
	wire trigB = compareBMatch & compareBUsesTimer & (compareBMode == `CMP_MODE_TRIGGER);
	wire trigReset = trigA | trigB;
	wire wrCount = wrLow | (wrHigh & ~wideAccess);
	wire wrap = countTick & (&countPair) & ~wrCount & ~trigReset;
	wire flagClear = wrStb && avs_address == `OFS_FLAGS_ONE && !wd[`BIT_OVF_FLAG];

	always @(posedge core_clk) begin
		if (srst) begin
			countPair <= {COUNT_WIDTH{1'b0}};
			highBuffer <= 8'h00;
		end else begin
			if (rdStb && avs_address == `OFS_COUNT_LOW)
				highBuffer <= countPair[15:8];
			if (wrHigh && wideAccess)
				highBuffer <= wd;
			if (wrLow)
				countPair <= {wideAccess ? highBuffer : countPair[15:8], wd};
			else if (wrHigh && !wideAccess)
				countPair <= {wd, countPair[7:0]};
			else if (trigReset)
				countPair <= {COUNT_WIDTH{1'b0}};
			else if (countTick)
				countPair <= countPair + 16'h0001;
		end
	end

	always @(posedge core_clk) begin
		if (srst)
			overflowIrqFlag <= 1'b0;
		else if (wrap)
			overflowIrqFlag <= 1'b1;
		else if (flagClear)
			overflowIrqFlag <= 1'b0;
	end

	always @(posedge core_clk) begin
		if (srst)
			adcStart <= 1'b0;
		else
			adcStart <= trigB & adcEnabled;
	end
endmodule // timer1_osc_overflow_trigger
`default_nettype wire

// *** timer1_osc_overflow_trigger_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module tmr_chk (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic secOscOutPinOe,
	input wire logic pinInputsRead,
	input wire logic secOscFailed,
	input wire logic compareBMatch,
	input wire logic [3:0] compareBMode,
	input wire logic compareBUsesTimer,
	input wire logic adcEnabled,
	input wire logic adcStart,
	input wire logic overflowIrq,
	input wire logic secOscRunning,
	input wire logic secRunMode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	pins_zero_a: assert property (!pinInputsRead) else $error("pins");
	run_mode_a: assert property (secRunMode == secOscRunning) else $error("run");
	fail_drop_a: assert property (secOscFailed |-> !secOscRunning) else $error("fail");
	osc_off_a: assert property (!secOscOutPinOe |-> !secOscRunning) else $error("osc");
	adc_cause_a: assert property (adcStart |-> $past(compareBMatch) && $past(adcEnabled))
		else $error("adc cause");
	adc_start_a: assert property (compareBMatch && adcEnabled && compareBUsesTimer
		&& compareBMode == 4'hb |=> adcStart) else $error("adc start");
	irq_sticky_a: assert property (overflowIrq && !avs_write |=> overflowIrq)
		else $error("irq");
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait");
endmodule // tmr_chk
bind timer1_osc_overflow_trigger tmr_chk u_chk (.core_clk, .srst, .avs_read, .avs_write,
	.avs_waitrequest, .secOscOutPinOe, .pinInputsRead, .secOscFailed, .compareBMatch,
	.compareBMode, .compareBUsesTimer, .adcEnabled, .adcStart, .overflowIrq, .secOscRunning,
	.secRunMode);
`default_nettype wire

// *** watch_crystal_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module watch_crystal_model (
	input wire logic amplifierOe,
	output var logic crystalIn,
	output var logic crystalOut
);
	initial crystalIn = 1'b0;
	// swings only while the amplifier drives it
	always begin
		#160;
		if (amplifierOe)
			crystalIn = ~crystalIn;
	end
	assign crystalOut = ~crystalIn;
endmodule // watch_crystal_model
`default_nettype wire

// *** test_timer1_osc_overflow_trigger.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_timer1_osc_overflow_trigger;
	logic core_clk = 0, srst = 1, avs_read = 0, avs_write = 0, sleepExecute = 0;
	logic secOscFailed = 0, compareAMatch = 0, compareBMatch = 0, extClockPin = 0;
	logic compareAUsesTimer = 1, compareBUsesTimer = 1, adcEnabled = 1;
	logic [3:0] compareAMode = 4'h0, compareBMode = 4'h0, avs_byteenable = 4'hf;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, rdata = 32'h0, lfsr = 32'h6734;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, secOscInPin, secOscOutPinIn, secOscOutPinOe, overflowIrq, secIdleMode;
	int n_errors = 0, compares = 0, k;
	always #20 core_clk = ~core_clk;
	timer1_osc_overflow_trigger uut (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .secOscInPin,
		.secOscOutPinIn, .secOscOutPinOut(), .secOscOutPinOe, .extClockPin, .pinInputsRead(),
		.sleepExecute, .secOscFailed, .compareAMatch, .compareAMode, .compareAUsesTimer,
		.compareBMatch, .compareBMode, .compareBUsesTimer, .adcEnabled, .adcStart(),
		.overflowIrq, .overflowIrqHighPriority(), .secOscRunning(), .secRunMode(), .secIdleMode);
	watch_crystal_model xtal (.amplifierOe(secOscOutPinOe), .crystalIn(secOscInPin),
		.crystalOut(secOscOutPinIn));
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic final_report;
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (e !== g) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		@(posedge core_clk);
		for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++)
			@(posedge core_clk);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(negedge core_clk);
		if (i == 20) begin
			n_errors++;
			final_report();
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e, input string s);
		bus(1'b0, a, 8'h00);
		check(s, {24'h0, e}, rdata);
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		rd(5'h08, 8'h00, "control reset");
		rd(5'h14, 8'h01, "priority reset");
		rd(5'h1c, 8'h00, "unmapped");
		for (k = 0; k < 4; k++) begin
			lfsr = nextRand(lfsr);
			bus(1'b1, 5'h00, lfsr[7:0]);
			bus(1'b1, 5'h04, lfsr[15:8]);
			rd(5'h00, lfsr[7:0], "count low");
			rd(5'h04, lfsr[15:8], "count high");
		end
		bus(1'b1, 5'h04, 8'hff);
		bus(1'b1, 5'h00, 8'hf0);
		bus(1'b1, 5'h08, 8'h01);
		rdata = 32'h0;
		for (k = 0; k < 60 && rdata[0] !== 1'b1; k++) begin
			bus(1'b0, 5'h0c, 8'h00);
			check("masked irq", 1'b0, overflowIrq);
		end
		check("wrap flag", 1'b1, rdata[0]);
		rd(5'h04, 8'h00, "wrapped high");
		bus(1'b1, 5'h10, 8'h01);
		check("irq enabled", 1'b1, overflowIrq);
		bus(1'b1, 5'h0c, 8'h00);
		check("irq cleared", 1'b0, overflowIrq);
		bus(1'b1, 5'h08, 8'h00);
		for (k = 0; k < 4; k++) begin
			lfsr = nextRand(lfsr);
			bus(1'b1, 5'h04, 8'h80);
			compareAMode <= k[1] ? 4'hb : {1'b0, lfsr[2:0]};
			compareBMode <= k[1] ? 4'hb : {1'b0, lfsr[2:0]};
			compareAMatch <= !k[0];
			compareBMatch <= k[0];
			@(posedge core_clk);
			compareAMatch <= 1'b0;
			compareBMatch <= 1'b0;
			rd(5'h04, k[1] ? 8'h00 : 8'h80, "trigger clear");
			rd(5'h0c, 8'h00, "trigger flag");
		end
		compareAMatch <= 1'b1;
		bus(1'b1, 5'h04, 8'h55);
		compareAMatch <= 1'b0;
		rd(5'h04, 8'h55, "write wins");
		bus(1'b1, 5'h18, 8'h01);
		bus(1'b1, 5'h08, 8'h0b);
		repeat (16) @(posedge core_clk);
		rd(5'h08, 8'h4b, "clock status");
		bus(1'b1, 5'h00, 8'h00);
		rdata = 32'h0;
		for (k = 0; k < 60 && rdata[7:0] < 8'h0a; k++)
			bus(1'b0, 5'h00, 8'h00);
		check("osc edge rate", 1'b1, k >= 22 && k <= 31);
		sleepExecute <= 1'b1;
		@(posedge core_clk);
		sleepExecute <= 1'b0;
		@(posedge core_clk);
		check("idle mode", 1'b1, secIdleMode);
		check("osc kept", 1'b1, secOscOutPinOe);
		secOscFailed <= 1'b1;
		rd(5'h08, 8'h0b, "failed status");
		final_report();
	end
endmodule // test_timer1_osc_overflow_trigger
`default_nettype wire
